// >>> cscr_pkg.sv
// Constants and carrier types for the current-sense routing block
package cscr_pkg;
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W  = 10;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ACC_CH1  = 10'h188;
	localparam logic [9:0] IDX_ACC_CH2  = 10'h189;
	localparam logic [9:0] IDX_FILT_12  = 10'h198;
	localparam logic [9:0] IDX_FILT_34  = 10'h199;
	localparam logic [9:0] IDX_FILT_4X  = 10'h19a;
	localparam logic [9:0] IDX_LINK     = 10'h1a8;
	localparam logic [9:0] IDX_SETTLE   = 10'h1a9;
	localparam logic [9:0] IDX_MON_ONE  = 10'h1aa;
	localparam logic [9:0] IDX_MON_TWO  = 10'h1ab;
	// Writable bit masks
	localparam logic [15:0] ACC_MASK    = 16'h03ff;
	localparam logic [15:0] FILT_MASK   = 16'h0fff;
	localparam logic [15:0] LINK_MASK   = 16'h00ff;
	localparam logic [15:0] SETTLE_MASK = 16'h003f;
	localparam logic [15:0] MON_MASK    = 16'h003f;
	// Reset values
	localparam logic [15:0] ACC_CH1_RST = 16'h0041;
	localparam logic [15:0] ACC_CH2_RST = 16'h0304;
	localparam logic [15:0] FILT_RST    = 16'h0041;
	localparam logic [15:0] LINK_RST    = 16'h007f;
	localparam logic [15:0] SETTLE_RST  = 16'h0000;
	localparam logic [15:0] MON_RST     = 16'h0000;
	// Field positions
	localparam int unsigned LINK_DIS_BIT  = 7;
	localparam int unsigned ACC_CORE_W    = 5;
	localparam int unsigned FLEN_ONE_LSB  = 0;
	localparam int unsigned FLEN_TWO_LSB  = 6;
	localparam int unsigned MON_EN_BIT    = 0;
	localparam int unsigned MON_GAIN_LSB  = 1;
	localparam int unsigned MON_SRC_LSB   = 3;
	// Monitor source codes
	localparam logic [2:0] MON_SRC_PRI = 3'h0;
	localparam logic [2:0] MON_SRC_ALT = 3'h1;
	localparam logic [2:0] MON_SRC_REF = 3'h5;
	// Settling window extra cycles
	localparam logic [7:0] SETTLE_EXTRA = 8'h04;
	// Fixed selector map, [core][selector] -> block
	localparam logic [3:0][3:0][1:0] DAC_MAP = 32'h1b4eb1e4;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// One control set for a current block
	typedef struct packed {
		logic [7:0] thr;
		logic [1:0] gain;
		logic       ofs;
		logic       conv;
	} ctrl_set_t;
	// One change request from a microcore selector
	typedef struct packed {
		logic      valid;
		ctrl_set_t set;
	} uc_req_t;
	// Analogue monitor routing
	typedef enum logic [1:0] {MON_NONE, MON_BLK_PRI, MON_BLK_ALT, MON_REF} mon_sel_t;
endpackage : cscr_pkg

// >>> cscr.sv
// Current-sense routing, settling window, monitor select and switch box
//
// Behaviour
// - HS5 coupling high when linked low-side on
// - Disable bit forces HS5 coupling to one
// - Threshold write invalidates feedback settle+filter+4
// - Wait checks false during settling window
// - Filter depth from per-block filter registers
// - Monitor enable with source code 0, 1 or 5 drives pin, else high impedance
// - Two-bit gain selects monitor amplification
// - Monitor one selects block 1/3/reference
// - Monitor two selects block 2/4/reference
// - Each block gets threshold, gain, offset, conversion
// - Switch box merges authorised core sets per block
// - Four offset compensation units, one per block
// - Channel-one cores use fixed selector map
// - Channel-two cores use fixed selector map
// - Access bit gates each core per block
// - Same-cycle collisions use fixed core priority
// - Different-cycle requests all applied in order
`timescale 1ns/1ns
module cscr
	import cscr_pkg::*;
(
	input  wire logic                  CLK_SYS,
	input  wire logic                  ARST_N,
	input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [DATA_W-1:0]     S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	output logic [DATA_W-1:0]          S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	input  wire logic [6:0]            LOW_SIDE_ON,
	output logic                       HS_FIVE_COUPLING_SIGNAL,
	input  wire uc_req_t [3:0][3:0]    UC_REQ,
	input  wire logic [3:0]            FB_COND,
	output logic [3:0]                 WAIT_COND_TRUE,
	output logic [3:0]                 FB_VALID,
	output ctrl_set_t [3:0]            CUR_SET,
	input  wire logic [3:0][7:0]       OFS_SAMPLE,
	output logic [3:0][7:0]            OFS_COMP,
	output logic                       MONITOR_PIN_ONE_OE,
	output mon_sel_t                   MONITOR_PIN_ONE_SEL,
	output logic [1:0]                 MONITOR_PIN_ONE_GAIN,
	output logic                       MONITOR_PIN_TWO_OE,
	output mon_sel_t                   MONITOR_PIN_TWO_SEL,
	output logic [1:0]                 MONITOR_PIN_TWO_GAIN
);

	////////////////////////////////////////////////////////////////////////
	// State

	// Whole state of the block in one struct
	typedef struct packed {
		logic                 awready;   // Write address slot free
		logic                 wready;    // Write data slot free
		logic                 aw_hold;   // Address captured
		logic [ADDR_W-1:0]    aw_addr;   // Captured write address
		logic                 w_hold;    // Data captured
		logic [15:0]          w_data;    // Captured low half of data
		logic [1:0]           w_strb;    // Captured low lane strobes
		logic                 bvalid;    // Write answer pending
		logic [1:0]           bresp;     // Write answer code
		logic                 arready;   // Read slot free
		logic                 rvalid;    // Read answer pending
		logic [1:0]           rresp;     // Read answer code
		logic [15:0]          rdata;     // Read answer data
		logic [15:0]          acc_ch1;   // Access rights, channel one
		logic [15:0]          acc_ch2;   // Access rights, channel two
		logic [15:0]          filt_12;   // Filter config blocks 1, 2
		logic [15:0]          filt_34;   // Filter config blocks 3, 4
		logic [15:0]          filt_4x;   // Filter config block 4 extra
		logic [15:0]          link;      // HS5 link and disable
		logic [15:0]          settle;    // Converter settle count
		logic [15:0]          mon_one;   // Monitor one config
		logic [15:0]          mon_two;   // Monitor two config
		ctrl_set_t [3:0]      cur;       // Merged control per block
		logic [3:0][7:0]      cnt;       // Settling countdown
		logic [3:0]           fb_valid;  // Feedback currently valid
		logic [3:0]           wait_ok;   // Gated wait condition
		logic [3:0][7:0]      ofs;       // Offset compensation value
		logic                 hs5;       // HS5 coupling level
		logic                 m1_oe;     // Monitor one drive
		mon_sel_t             m1_sel;    // Monitor one route
		logic [1:0]           m1_gain;   // Monitor one gain
		logic                 m2_oe;     // Monitor two drive
		mon_sel_t             m2_sel;    // Monitor two route
		logic [1:0]           m2_gain;   // Monitor two gain
	} state_t;

	// Reset image; slots open, feedback valid, registers at defaults
	localparam state_t ST_RST = '{
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		acc_ch1: ACC_CH1_RST, acc_ch2: ACC_CH2_RST,
		filt_12: FILT_RST, filt_34: FILT_RST, filt_4x: FILT_RST,
		link: LINK_RST, settle: SETTLE_RST,
		mon_one: MON_RST, mon_two: MON_RST,
		fb_valid: 4'hf, m1_sel: MON_NONE, m2_sel: MON_NONE,
		default: '0
	};

	state_t s_q;   // Registered state
	state_t s_d;   // Next state

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Decode a byte address to a register number, 9 when unmapped
	function automatic logic [3:0] reg_num(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] idx;
		idx = a[ADDR_W-1:2];
		reg_num = 4'h9;
		if (a[1:0] == 2'h0) begin
			case (idx)
				IDX_ACC_CH1: reg_num = 4'h0;
				IDX_ACC_CH2: reg_num = 4'h1;
				IDX_FILT_12: reg_num = 4'h2;
				IDX_FILT_34: reg_num = 4'h3;
				IDX_FILT_4X: reg_num = 4'h4;
				IDX_LINK:    reg_num = 4'h5;
				IDX_SETTLE:  reg_num = 4'h6;
				IDX_MON_ONE: reg_num = 4'h7;
				IDX_MON_TWO: reg_num = 4'h8;
				default:     reg_num = 4'h9;
			endcase
		end
	endfunction : reg_num

	// Byte-lane merge, reserved bits kept at zero
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
			input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] m;
		m = old;
		if (strb[0]) begin
			m[7:0] = dat[7:0];
		end
		if (strb[1]) begin
			m[15:8] = dat[15:8];
		end
		merge = m & mask;
	endfunction : merge

	// Monitor route from config; other codes undriven
	function automatic mon_sel_t mon_route(input logic [15:0] cfg);
		logic [2:0] src;
		src = cfg[MON_SRC_LSB +: 3];
		if (!cfg[MON_EN_BIT]) begin
			mon_route = MON_NONE;
		end else begin
			case (src)
				MON_SRC_PRI: mon_route = MON_BLK_PRI;
				MON_SRC_ALT: mon_route = MON_BLK_ALT;
				MON_SRC_REF: mon_route = MON_REF;
				default:     mon_route = MON_NONE;
			endcase
		end
	endfunction : mon_route

	// Filter depth of one block
	function automatic logic [4:0] flen(input logic [15:0] f12, input logic [15:0] f34,
			input logic [1:0] blk);
		case (blk)
			2'h0:    flen = f12[FLEN_ONE_LSB +: 5];
			2'h1:    flen = f12[FLEN_TWO_LSB +: 5];
			2'h2:    flen = f34[FLEN_ONE_LSB +: 5];
			default: flen = f34[FLEN_TWO_LSB +: 5];
		endcase
	endfunction : flen

	// Access right of one core on one block; block 4 uses bit 3 of the core's five
	function automatic logic acc_ok(input logic [15:0] a1, input logic [15:0] a2,
			input logic [1:0] core, input logic [1:0] blk);
		logic [15:0] a;
		a = core[1] ? a2 : a1;
		acc_ok = a[ACC_CORE_W * core[0] + blk];
	endfunction : acc_ok

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Bus slave, register file, switch box and routing
	always_comb begin
		logic [3:0]   wr_num;
		logic         hit;
		ctrl_set_t    win;
		logic [1:0]   blk;
		s_d    = s_q;
		wr_num = 4'h9;
		hit    = 1'b0;
		win    = '0;
		blk    = 2'h0;

		// Capture address and data in either order
		if (S_AXI_AWVALID && s_q.awready) begin
			s_d.aw_hold = 1'b1;
			s_d.aw_addr = S_AXI_AWADDR;
			s_d.awready = 1'b0;
		end
		if (S_AXI_WVALID && s_q.wready) begin
			s_d.w_hold = 1'b1;
			s_d.w_data = S_AXI_WDATA[15:0];
			s_d.w_strb = S_AXI_WSTRB[1:0];
			s_d.wready = 1'b0;
		end

		// Both halves present: perform the write
		if (s_d.aw_hold && s_d.w_hold && !s_q.bvalid) begin
			wr_num     = reg_num(s_d.aw_addr);
			s_d.bvalid = 1'b1;
			s_d.bresp  = (wr_num == 4'h9) ? RESP_SLVERR : RESP_OKAY;
			s_d.aw_hold = 1'b0;
			s_d.w_hold  = 1'b0;
			case (wr_num)
				4'h0: s_d.acc_ch1 = merge(s_q.acc_ch1, s_d.w_data, s_d.w_strb, ACC_MASK);
				4'h1: s_d.acc_ch2 = merge(s_q.acc_ch2, s_d.w_data, s_d.w_strb, ACC_MASK);
				4'h2: s_d.filt_12 = merge(s_q.filt_12, s_d.w_data, s_d.w_strb, FILT_MASK);
				4'h3: s_d.filt_34 = merge(s_q.filt_34, s_d.w_data, s_d.w_strb, FILT_MASK);
				4'h4: s_d.filt_4x = merge(s_q.filt_4x, s_d.w_data, s_d.w_strb, FILT_MASK);
				4'h5: s_d.link    = merge(s_q.link, s_d.w_data, s_d.w_strb, LINK_MASK);
				4'h6: s_d.settle  = merge(s_q.settle, s_d.w_data, s_d.w_strb, SETTLE_MASK);
				4'h7: s_d.mon_one = merge(s_q.mon_one, s_d.w_data, s_d.w_strb, MON_MASK);
				4'h8: s_d.mon_two = merge(s_q.mon_two, s_d.w_data, s_d.w_strb, MON_MASK);
				default: ;  // Unmapped: answered with an error only
			endcase
		end

		// Write answer taken: reopen both slots
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid  = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end

		// Read: data one cycle after the address is taken
		if (S_AXI_ARVALID && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rresp   = RESP_OKAY;
			case (reg_num(S_AXI_ARADDR))
				4'h0:    s_d.rdata = s_q.acc_ch1;
				4'h1:    s_d.rdata = s_q.acc_ch2;
				4'h2:    s_d.rdata = s_q.filt_12;
				4'h3:    s_d.rdata = s_q.filt_34;
				4'h4:    s_d.rdata = s_q.filt_4x;
				4'h5:    s_d.rdata = s_q.link;
				4'h6:    s_d.rdata = s_q.settle;
				4'h7:    s_d.rdata = s_q.mon_one;
				4'h8:    s_d.rdata = s_q.mon_two;
				default: begin
					s_d.rdata = '0;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end

		// Switch box: per block, lowest core number wins a collision.
		// Losers in the same cycle are dropped and never retried.
		for (int b = 0; b < 4; b++) begin
			hit = 1'b0;
			win = '0;
			for (int c = 3; c >= 0; c--) begin
				for (int sl = 0; sl < 4; sl++) begin
					blk = DAC_MAP[c][sl];
					if (UC_REQ[c][sl].valid && (blk == 2'(b))
							&& acc_ok(s_q.acc_ch1, s_q.acc_ch2, 2'(c), blk)) begin
						hit = 1'b1;
						win = UC_REQ[c][sl].set;
					end
				end
			end
			if (hit) begin
				// Every applied request lands the same cycle
				s_d.cur[b] = win;
				s_d.cnt[b] = 8'(s_q.settle[5:0])
					+ 8'(flen(s_q.filt_12, s_q.filt_34, 2'(b)))
					+ SETTLE_EXTRA;
				if (win.ofs) begin
					s_d.ofs[b] = OFS_SAMPLE[b];
				end
			end else if (s_q.cnt[b] != 8'h00) begin
				s_d.cnt[b] = s_q.cnt[b] - 8'h01;
			end
			s_d.fb_valid[b] = (s_d.cnt[b] == 8'h00);
		end
		// Wait checks cannot succeed inside a window
		s_d.wait_ok = FB_COND & s_d.fb_valid;

		// HS5 coupling
		s_d.hs5 = s_q.link[LINK_DIS_BIT]
			| (|(LOW_SIDE_ON & s_q.link[6:0]));

		// Monitor outputs
		s_d.m1_sel  = mon_route(s_q.mon_one);
		s_d.m1_oe   = (s_d.m1_sel != MON_NONE);
		s_d.m1_gain = s_q.mon_one[MON_GAIN_LSB +: 2];
		s_d.m2_sel  = mon_route(s_q.mon_two);
		s_d.m2_oe   = (s_d.m2_sel != MON_NONE);
		s_d.m2_gain = s_q.mon_two[MON_GAIN_LSB +: 2];
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Single register stage for all state
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops

	assign S_AXI_AWREADY = s_q.awready;
	assign S_AXI_WREADY  = s_q.wready;
	assign S_AXI_BVALID  = s_q.bvalid;
	assign S_AXI_BRESP   = s_q.bresp;
	assign S_AXI_ARREADY = s_q.arready;
	assign S_AXI_RVALID  = s_q.rvalid;
	assign S_AXI_RRESP   = s_q.rresp;
	assign S_AXI_RDATA   = {16'h0000, s_q.rdata};
	assign HS_FIVE_COUPLING_SIGNAL = s_q.hs5;
	assign WAIT_COND_TRUE = s_q.wait_ok;
	assign FB_VALID       = s_q.fb_valid;
	assign CUR_SET        = s_q.cur;
	assign OFS_COMP       = s_q.ofs;
	assign MONITOR_PIN_ONE_OE   = s_q.m1_oe;
	assign MONITOR_PIN_ONE_SEL  = s_q.m1_sel;
	assign MONITOR_PIN_ONE_GAIN = s_q.m1_gain;
	assign MONITOR_PIN_TWO_OE   = s_q.m2_oe;
	assign MONITOR_PIN_TWO_SEL  = s_q.m2_sel;
	assign MONITOR_PIN_TWO_GAIN = s_q.m2_gain;

endmodule : cscr

// >>> cscr_monitor.sv
// Port-level checks for the current-sense routing block
`timescale 1ns/1ns
module cscr_monitor
	import cscr_pkg::*;
(
	input wire logic              CLK_SYS,
	input wire logic              ARST_N,
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic [1:0]        S_AXI_BRESP,
	input wire logic              S_AXI_BVALID,
	input wire logic              S_AXI_BREADY,
	input wire logic [DATA_W-1:0] S_AXI_RDATA,
	input wire logic              S_AXI_RVALID,
	input wire logic              S_AXI_RREADY,
	input wire uc_req_t [3:0][3:0] UC_REQ,
	input wire logic [3:0]        WAIT_COND_TRUE,
	input wire logic [3:0]        FB_VALID,
	input wire ctrl_set_t [3:0]   CUR_SET,
	input wire logic              MONITOR_PIN_ONE_OE,
	input wire mon_sel_t          MONITOR_PIN_ONE_SEL,
	input wire logic              MONITOR_PIN_TWO_OE,
	input wire mon_sel_t          MONITOR_PIN_TWO_SEL
);
	logic any_req; // Any core request in this cycle
	////////////////////////////////////////////////////////////////
	// Collapse all request strobes; sets may only move after one
	always_comb begin
		any_req = 1'b0;
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 4; s++)
				any_req = any_req | UC_REQ[c][s].valid;
	end
	default clocking dc @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	// Shortest window: zero settle, zero filter, four extra
	sequence s_fb_low4;
		!FB_VALID[0] [*4];
	endsequence
	sequence s_wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	////////////////////////////////////////////////////////////////
	chk_fb_drop: assert property ($changed(CUR_SET[0]) |-> !FB_VALID[0])
		else $error("feedback still valid on a new set");
	chk_fb_window: assert property ($fell(FB_VALID[0]) |-> s_fb_low4)
		else $error("settling window too short");
	chk_wait_gate: assert property ((WAIT_COND_TRUE & ~FB_VALID) == 4'h0)
		else $error("wait check true inside window");
	chk_set_quiet: assert property (!any_req |=> $stable(CUR_SET))
		else $error("control set moved without a request");
	chk_mon_one_off: assert property (MONITOR_PIN_ONE_SEL == MON_NONE |-> !MONITOR_PIN_ONE_OE)
		else $error("pin one driven with no source");
	chk_mon_two_off: assert property (MONITOR_PIN_TWO_SEL == MON_NONE |-> !MONITOR_PIN_TWO_OE)
		else $error("pin two driven with no source");
	chk_b_answer: assert property (s_wr_taken |=> S_AXI_BVALID)
		else $error("no write response");
	chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
endmodule : cscr_monitor

bind cscr cscr_monitor chk (.*);

// >>> uc_model.sv
// Behavioural model of the four microcores issuing change requests
`timescale 1ns/1ns
module uc_model
	import cscr_pkg::*;
(
	input wire logic           clk,
	output uc_req_t [3:0][3:0] req
);
	uc_req_t [3:0][3:0] pend; // Requests queued for the next edge
	initial begin
		req = '0;
		pend = '0;
	end
	// Queue one change; called between edges to avoid racing the flop
	task automatic post(input int c, input int s, input ctrl_set_t v);
		pend[c][s] = {1'b1, v};
	endtask : post
	// Each change is a one-cycle pulse, cores never hold a request
	always @(posedge clk) begin
		req <= pend;
		pend = '0;
	end
endmodule : uc_model

// >>> tb.sv
// Self-checking bench for the current-sense routing block
`timescale 1ns/1ns
module tb;
	import cscr_pkg::*;
	logic CLK_SYS, ARST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB, FB_COND, WAIT_COND_TRUE, FB_VALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, MONITOR_PIN_ONE_GAIN, MONITOR_PIN_TWO_GAIN;
	logic [6:0] LOW_SIDE_ON;
	logic HS_FIVE_COUPLING_SIGNAL, MONITOR_PIN_ONE_OE, MONITOR_PIN_TWO_OE;
	mon_sel_t MONITOR_PIN_ONE_SEL, MONITOR_PIN_TWO_SEL;
	uc_req_t [3:0][3:0] UC_REQ;
	ctrl_set_t [3:0] CUR_SET;
	logic [3:0][7:0] OFS_SAMPLE, OFS_COMP;
	int failures, n_tests;
	int seed = 15522;
	int flen[4] = '{2, 5, 9, 0}; // Filter depth chosen per block
	logic [9:0] ridx[9] = '{10'h188, 10'h189, 10'h198, 10'h199, 10'h19a,
		10'h1a8, 10'h1a9, 10'h1aa, 10'h1ab};
	logic [15:0] rrst[9] = '{16'h0041, 16'h0304, 16'h0041, 16'h0041, 16'h0041,
		16'h007f, 16'h0000, 16'h0000, 16'h0000};
	cscr dut (.*);
	uc_model cores (.clk(CLK_SYS), .req(UC_REQ));
	////////////////////////////////////////////////////////////////
	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end
	// Whole run is under a thousand cycles; this is far beyond it
	initial begin
		#400000;
		failures++;
		give_verdict();
	end
	// Wide enough for a response code beside a full data word
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		// Start just after a rising edge, whatever the caller waited on
		@(posedge CLK_SYS);
		S_AXI_AWADDR <= {idx, 2'h0};
		S_AXI_WDATA <= {16'h0000, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		while (!(aw && w)) begin
			@(posedge CLK_SYS);
			if (S_AXI_AWREADY) begin
				aw = 1'b1;
				S_AXI_AWVALID <= 1'b0;
			end
			if (S_AXI_WREADY) begin
				w = 1'b1;
				S_AXI_WVALID <= 1'b0;
			end
		end
		do @(posedge CLK_SYS); while (!S_AXI_BVALID);
		chk(S_AXI_BRESP, er);
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
		@(posedge CLK_SYS);
		S_AXI_ARADDR <= {idx, 2'h0};
		S_AXI_ARVALID <= 1'b1;
		do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CLK_SYS); while (!S_AXI_RVALID);
		chk({S_AXI_RRESP, S_AXI_RDATA}, {er, 16'h0000, d});
	endtask : rd
	// Model drives at one edge, design takes at the next
	task automatic go();
		repeat (2) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask : go
	task automatic hit(input int c, input int s, input ctrl_set_t v);
		@(negedge CLK_SYS);
		cores.post(c, s, v);
		go();
	endtask : hit
	// Cycles the block's feedback stays invalid after a take
	task automatic measure(input int b, output int k);
		k = 0;
		while (FB_VALID[b] !== 1'b1 && k < 200) begin
			if (k == 0) chk(WAIT_COND_TRUE[b], 1'b0);
			k++;
			@(negedge CLK_SYS);
		end
	endtask : measure
	task automatic give_verdict();
		$display("Counts: %0d compares, %0d mismatches", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////
	initial begin
		ctrl_set_t v;
		ctrl_set_t vals[4];
		logic [15:0] d;
		logic oe;
		mon_sel_t ms;
		logic [4:0] em;
		int k;
		// Answers always accepted: both ready lines stay high all run
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h05;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'h3;
		LOW_SIDE_ON = 7'h00;
		FB_COND = 4'hf;
		OFS_SAMPLE = {$random(seed)};
		ARST_N = 1'b0;
		repeat (4) @(posedge CLK_SYS);
		ARST_N <= 1'b1;
		// Reset values, then refused accesses off the map
		for (int i = 0; i < 9; i++) rd(ridx[i], rrst[i], RESP_OKAY);
		rd(10'h3ff, 16'h0000, RESP_SLVERR);
		wr(10'h3ff, 16'hffff, RESP_SLVERR);
		// High lane only: the low-byte count must keep its reset value
		S_AXI_WSTRB <= 4'h2;
		wr(IDX_SETTLE, 16'h00ff, RESP_OKAY);
		rd(IDX_SETTLE, 16'h0000, RESP_OKAY);
		S_AXI_WSTRB <= 4'h3;
		$display("Test registers done");
		// Coupling: first pass disabled with nothing on, then random
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 16'h0080 : 16'($random(seed));
			wr(IDX_LINK, d, RESP_OKAY); // Software link bits
			LOW_SIDE_ON <= (i == 0) ? 7'h00 : 7'($random(seed));
			go();
			chk(HS_FIVE_COUPLING_SIGNAL, d[7] | (|(LOW_SIDE_ON & d[6:0])));
		end
		$display("Test coupling done");
		// Every source code with both enables on both pins
		for (int i = 0; i < 32; i++) begin
			d = {16'($random(seed)) & 16'hffc6} | 16'(i % 16 / 2 << 3) | 16'(i % 2);
			wr(i < 16 ? IDX_MON_ONE : IDX_MON_TWO, d, RESP_OKAY);
			rd(i < 16 ? IDX_MON_ONE : IDX_MON_TWO, d & MON_MASK, RESP_OKAY);
			go();
			oe = d[0] && (d[5:3] == 3'h0 || d[5:3] == 3'h1 || d[5:3] == 3'h5);
			ms = (d[5:3] == 3'h0) ? MON_BLK_PRI : (d[5:3] == 3'h1) ? MON_BLK_ALT : MON_REF;
			// Undriven pin shows no route; gain still follows its field
			em = oe ? {1'b1, ms, d[2:1]} : {1'b0, MON_NONE, d[2:1]};
			if (i < 16) chk({MONITOR_PIN_ONE_OE, MONITOR_PIN_ONE_SEL,
				MONITOR_PIN_ONE_GAIN}, em);
			else chk({MONITOR_PIN_TWO_OE, MONITOR_PIN_TWO_SEL,
				MONITOR_PIN_TWO_GAIN}, em);
		end
		$display("Test monitor done");
		// Fixed map: block index is core xor selector
		wr(IDX_ACC_CH1, 16'h03ff, RESP_OKAY);
		wr(IDX_ACC_CH2, 16'h03ff, RESP_OKAY);
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 4; s++) begin
				v = 12'($random(seed));
				hit(c, s, v);
				chk(CUR_SET[c ^ s], v);
				if (v.ofs) chk(OFS_COMP[c ^ s], OFS_SAMPLE[c ^ s]);
			end
		$display("Test mapping done");
		// Collisions on block one with access taken away one core at a time
		for (int w = 0; w < 5; w++) begin
			wr(IDX_ACC_CH1, 16'h03ff & ~(w > 0 ? 16'h0001 : 16'h0) & ~(w > 1 ? 16'h0020 : 16'h0), RESP_OKAY);
			wr(IDX_ACC_CH2, 16'h03ff & ~(w > 2 ? 16'h0001 : 16'h0) & ~(w > 3 ? 16'h0020 : 16'h0), RESP_OKAY);
			d = 16'(CUR_SET[0]);
			@(negedge CLK_SYS);
			for (int c = 0; c < 4; c++) begin
				vals[c] = 12'($random(seed));
				cores.post(c, c, vals[c]);
			end
			go();
			chk(CUR_SET[0], w < 4 ? vals[w] : d[11:0]);
		end
		wr(IDX_ACC_CH1, 16'h03ff, RESP_OKAY);
		wr(IDX_ACC_CH2, 16'h03ff, RESP_OKAY);
		// Requests one cycle apart are both applied in turn
		vals[1] = 12'h5a1;
		vals[2] = 12'ha5e;
		@(negedge CLK_SYS);
		cores.post(1, 1, vals[1]);
		@(posedge CLK_SYS);
		@(negedge CLK_SYS);
		cores.post(2, 2, vals[2]);
		@(posedge CLK_SYS);
		@(negedge CLK_SYS);
		chk(CUR_SET[0], vals[1]);
		go();
		chk(CUR_SET[0], vals[2]);
		$display("Test priority done");
		// Window length per block, then a rewrite mid-window
		wr(IDX_SETTLE, 16'hffc6, RESP_OKAY);
		wr(IDX_FILT_12, 16'(flen[1] << 6 | flen[0]), RESP_OKAY);
		wr(IDX_FILT_34, 16'(flen[3] << 6 | flen[2]), RESP_OKAY);
		for (int b = 0; b < 4; b++) begin
			hit(0, b, 12'(b + 1));
			measure(b, k);
			chk(k, 6 + flen[b] + 4);
			@(negedge CLK_SYS);
			chk(WAIT_COND_TRUE[b], 1'b1);
		end
		hit(0, 0, 12'h0f1);
		repeat (3) @(posedge CLK_SYS);
		hit(0, 0, 12'h0f2);
		measure(0, k);
		chk(k, 6 + flen[0] + 4);
		$display("Test settling done");
		give_verdict();
	end
endmodule : tb
